// >>> design/kpa_access.sv
// Keypad navigation, editing and security control for the drive parameters.
// Assumes the parameter store answers attributes and data for the shown index
// combinationally, and accepts write, save, default and apply strobes.
//
// What this block does
// R01: Menus and visible parameters readable without code.
// R02: Invisible parameters need the correct code.
// R03: Each menu recalls its last selected parameter.
// R04: Level 3 code protects everything from power-on.
// R05: LEFT/RIGHT step menu, UP/DOWN parameter.
// R06: MODE, UP/DOWN while flashing, MODE accepts.
// R07: Serial and threshold destinations apply after RESET.
// R08: Unsaved values live only in volatile storage.
// R09: Parameter zero at 001 plus RESET saves.
// R10: 233 (four-quadrant) or 255 (one-quadrant) plus RESET restores defaults.
// R11: Flash only when writable, not input-controlled.
// R12: Read-only or locked data stays steady.
// R13: Free group writable at power-on without level 3.
// R14: Code 149 unlocks visible read-write parameters.
// R15: Code 200 unlocks all read-write parameters.
// R16: Saved security code 0 removes all protection.
// R17: Saved security code 149 restores level 1.
// R18: Level 3 code 1 to 255, not 149.
// R19: Saved level 3 code denies even reads.
// R20: After level 3, level 1 or 2 code next.
// R21: Level 1 failing means level 3 protects.
// R22: Unknown code leaves access level unchanged.
`timescale 1ns/1ps
`default_nettype none
`include "kpa_defines.svh"
module kpa_access
    import kpa_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Keypad pins
    input wire kpa_keys_t keys_pin,
    // Drive four-quadrant strap, a static level
    input wire logic four_quad,
    // Parameter store lookup for the shown index
    input wire kpa_attr_t attr,
    input wire logic [9:0] store_data,
    // Saved security code from non-volatile storage, valid after power-on
    input wire logic [9:0] saved_sec_code,
    // Display
    output kpa_index_t disp_index,
    output logic [9:0] disp_data,
    output logic disp_flash,
    output logic disp_blank,
    // Parameter store commands
    output logic wr_strobe,
    output kpa_index_t wr_index,
    output logic [9:0] wr_data,
    output logic save_strobe,
    output logic default_strobe,
    output logic default_four_quad,
    output logic apply_deferred
);
    kpa_keys_t key;
    kpa_state_t state;
    kpa_state_t next_state;
    kpa_level_t level;
    kpa_level_t next_level;
    logic l3_ok;
    logic next_l3_ok;
    logic [9:0] sec_code;
    logic [9:0] next_sec_code;
    logic sec_loaded;
    logic next_sec_loaded;
    logic [9:0] edit_val;
    logic [9:0] next_edit_val;
    logic [4:0] menu;
    logic [4:0] next_menu;
    logic [5:0] last_param [`KPA_NUM_MENUS];
    logic [5:0] cur_param;
    logic [5:0] next_param;
    logic param_we;
    logic [9:0] zero_val;
    logic [9:0] next_zero_val;
    logic deferred;
    logic next_deferred;
    logic fq_sampled;
    logic next_fq_sampled;
    logic fq_meta;
    logic [9:0] pend_sec;
    logic [9:0] next_pend_sec;
    logic wr_pulse;
    logic save_pulse;
    logic def_pulse;
    logic apply_pulse;
    logic reset_seen;
    logic [9:0] next_out_data;
    logic next_out_flash;
    logic can_write;
    logic can_read;
    logic l3_set;
    logic at_zero;
    logic at_sec;

    kpa_key_sync u_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .keys_pin(keys_pin),
        .key_press(key)
    );

    function automatic logic is_deferred(input logic [4:0] m, input logic [5:0] p);
        is_deferred = (m == `KPA_MENU_MISC && (p == `KPA_PAR_BAUD || p == `KPA_PAR_SMODE))
            || (m == `KPA_MENU_THR && (p == `KPA_PAR_THR1 || p == `KPA_PAR_THR2));
    endfunction : is_deferred

    assign cur_param = last_param[menu];
    assign at_zero = (cur_param == 6'h00);
    assign at_sec = (menu == `KPA_MENU_MISC) && (cur_param == `KPA_PAR_SEC);
    // Any code other than 0 and 149 is a private code.
    assign l3_set = sec_loaded && sec_code != 10'h000 && sec_code != `KPA_CODE_L1;
    // Parameter zero is the code entry point and stays reachable. [R19]
    assign can_read = at_zero || ((!l3_set || l3_ok)
        && (attr.visible || level == KPA_L2 || sec_code == 10'h000)); // [R01] [R02]

    always_comb
    begin
        can_write = 1'b0;
        if (at_zero)
            can_write = 1'b1;
        else if (!attr.writable || attr.prog_input || !can_read)
            can_write = 1'b0; // [R11] [R12]
        else if (sec_loaded && sec_code == 10'h000)
            can_write = 1'b1; // [R16]
        else if (level == KPA_L2)
            can_write = 1'b1; // [R15]
        else if (level == KPA_L1 && attr.visible)
            can_write = 1'b1; // [R14] [R21]
        else if (attr.free_group && !l3_set)
            can_write = 1'b1; // [R13] [R04]
    end

    always_comb
    begin
        next_state = state;
        next_level = level;
        next_l3_ok = l3_ok;
        next_sec_code = sec_code;
        next_sec_loaded = 1'b1;
        next_edit_val = edit_val;
        next_menu = menu;
        next_param = cur_param;
        param_we = 1'b0;
        next_zero_val = zero_val;
        next_deferred = deferred;
        next_fq_sampled = fq_sampled;
        wr_pulse = 1'b0;
        save_pulse = 1'b0;
        def_pulse = 1'b0;
        apply_pulse = 1'b0;
        reset_seen = key.reset;
        if (!sec_loaded)
        begin
            next_sec_code = saved_sec_code;
            next_fq_sampled = fq_meta;
        end
        unique case (state)
            KPA_BROWSE:
            begin
                if (key.left || key.right)
                begin
                    if (key.right)
                        next_menu = (menu == 5'(`KPA_NUM_MENUS - 1)) ? 5'h00 : menu + 5'h01;
                    else
                        next_menu = (menu == 5'h00) ? 5'(`KPA_NUM_MENUS - 1) : menu - 5'h01;
                end // [R05] [R03]
                else if (key.up || key.down)
                begin
                    param_we = 1'b1;
                    if (key.up)
                        next_param = (cur_param == `KPA_MAX_PARAM) ? 6'h00 : cur_param + 6'h01;
                    else
                        next_param = (cur_param == 6'h00) ? `KPA_MAX_PARAM : cur_param - 6'h01;
                end // [R05] [R03]
                else if (key.mode && can_read)
                begin
                    // Editing starts from the value on show. [R18]
                    next_edit_val = next_out_data;
                    next_state = can_write ? KPA_EDIT : KPA_VIEW; // [R06] [R11] [R12]
                end
                else if (reset_seen)
                begin
                    if (at_zero && zero_val == `KPA_CODE_SAVE)
                    begin
                        save_pulse = 1'b1; // [R09] [R16] [R17]
                        next_sec_code = pend_sec; // [R16] [R17]
                    end
                    if (at_zero && ((zero_val == `KPA_CODE_DEF4Q && fq_sampled)
                        || (zero_val == `KPA_CODE_DEF1Q && !fq_sampled)))
                        def_pulse = 1'b1; // [R10]
                    if (deferred)
                        apply_pulse = 1'b1; // [R07]
                    next_deferred = 1'b0;
                    next_zero_val = 10'h000;
                end
            end
            KPA_EDIT:
            begin
                if (key.up && edit_val != 10'h3FF)
                    next_edit_val = edit_val + 10'h001; // [R06]
                else if (key.down && edit_val != 10'h000)
                    next_edit_val = edit_val - 10'h001; // [R06]
                else if (key.mode)
                begin
                    next_state = KPA_BROWSE;
                    if (at_zero)
                    begin
                        next_zero_val = edit_val;
                        if (l3_set && !l3_ok)
                        begin
                            if (edit_val == sec_code)
                                next_l3_ok = 1'b1; // [R19] [R20]
                        end
                        else if (edit_val == `KPA_CODE_L2)
                            next_level = KPA_L2; // [R15] [R20]
                        else if (edit_val == `KPA_CODE_L1 && level != KPA_L2)
                            next_level = KPA_L1; // [R14] [R20]
                        // Other values keep the level as it stands. [R22]
                    end
                    else if (at_sec && (edit_val > `KPA_CODE_MAX))
                        next_state = KPA_BROWSE; // [R18]
                    else
                    begin
                        wr_pulse = 1'b1; // [R07] [R08]
                        if (is_deferred(menu, cur_param))
                            next_deferred = 1'b1; // [R07]
                    end
                end
            end
            KPA_VIEW:
            begin
                if (key.mode || key.left || key.right || key.up || key.down)
                    next_state = KPA_BROWSE;
            end
            default:
                next_state = KPA_BROWSE;
        endcase
        if (srst)
        begin
            next_state = KPA_BROWSE;
            next_level = KPA_NONE;
            next_l3_ok = 1'b0;
            next_sec_loaded = 1'b0;
            next_sec_code = 10'h000;
            next_menu = 5'h00;
            next_zero_val = 10'h000;
            next_deferred = 1'b0;
            param_we = 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        state <= next_state;
        level <= next_level;
        l3_ok <= next_l3_ok;
        sec_code <= next_sec_code;
        sec_loaded <= next_sec_loaded;
        edit_val <= next_edit_val;
        menu <= next_menu;
        zero_val <= next_zero_val;
        deferred <= next_deferred;
        fq_sampled <= next_fq_sampled;
        fq_meta <= four_quad;
    end

    // Last-parameter memory, cleared at power-on reset. [R03]
    always_ff @(posedge ref_clk)
    begin
        for (int i = 0; i < `KPA_NUM_MENUS; i++)
        begin
            if (srst)
                last_param[i] <= 6'h00;
            else if (param_we && menu == 5'(i))
                last_param[i] <= next_param;
        end
    end

    // The new code only takes hold once saved. [R16] [R17] [R18]
    always_comb
    begin
        next_pend_sec = pend_sec;
        if (wr_pulse && at_sec)
            next_pend_sec = edit_val;
        if (srst || !sec_loaded)
            next_pend_sec = saved_sec_code;
    end

    always_ff @(posedge ref_clk)
    begin
        pend_sec <= next_pend_sec;
    end

    always_comb
    begin
        next_out_data = store_data;
        next_out_flash = 1'b0;
        if (state == KPA_EDIT)
        begin
            next_out_data = edit_val;
            next_out_flash = 1'b1; // [R11]
        end
        else if (at_zero)
            next_out_data = zero_val;
        else if (at_sec && level == KPA_L2)
            next_out_data = sec_code == 10'h000 ? pend_sec : `KPA_CODE_L1; // [R18]
        if (srst)
        begin
            next_out_data = 10'h000;
            next_out_flash = 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        disp_data <= next_out_data;
        disp_flash <= next_out_flash;
        disp_blank <= srst ? 1'b0 : !can_read; // [R19]
        wr_strobe <= srst ? 1'b0 : wr_pulse;
        wr_index <= srst ? '0 : {menu, cur_param};
        wr_data <= srst ? 10'h000 : edit_val;
        save_strobe <= srst ? 1'b0 : save_pulse;
        default_strobe <= srst ? 1'b0 : def_pulse;
        default_four_quad <= srst ? 1'b0 : fq_sampled;
        apply_deferred <= srst ? 1'b0 : apply_pulse;
    end

    assign disp_index = '{menu: menu, param: cur_param};
endmodule : kpa_access
`default_nettype wire

// >>> design/kpa_defines.svh
// Constants for the keypad parameter access and security block.
// Assumes inclusion by bare name from design files.
`ifndef KPA_DEFINES_SVH
`define KPA_DEFINES_SVH

`define KPA_NUM_MENUS 17
`define KPA_MAX_PARAM 6'h3F
`define KPA_CODE_L1 10'h095
`define KPA_CODE_L2 10'h0C8
`define KPA_CODE_SAVE 10'h001
`define KPA_CODE_DEF4Q 10'h0E9
`define KPA_CODE_DEF1Q 10'h0FF
`define KPA_CODE_MAX 10'h0FF
`define KPA_MENU_MISC 5'h0B
`define KPA_MENU_THR 5'h0C
`define KPA_PAR_BAUD 6'h0C
`define KPA_PAR_SMODE 6'h0D
`define KPA_PAR_SEC 6'h11
`define KPA_PAR_THR1 6'h07
`define KPA_PAR_THR2 6'h0C
`define KPA_PAR_UPTR_LO 6'h01
`define KPA_PAR_UPTR_HI 6'h0A

`endif

// >>> design/kpa_pkg.sv
// Types shared by the keypad parameter access block.
// Assumes kpa_defines.svh supplies the numeric constants.
package kpa_pkg;

    typedef enum logic [2:0] {
        KPA_NONE = 3'b001,
        KPA_L1 = 3'b010,
        KPA_L2 = 3'b100
    } kpa_level_t;

    typedef enum logic [2:0] {
        KPA_BROWSE = 3'b001,
        KPA_EDIT = 3'b010,
        KPA_VIEW = 3'b100
    } kpa_state_t;

    typedef struct packed {
        logic left;
        logic right;
        logic up;
        logic down;
        logic mode;
        logic reset;
    } kpa_keys_t;

    typedef struct packed {
        logic [4:0] menu;
        logic [5:0] param;
    } kpa_index_t;

    typedef struct packed {
        logic visible;
        logic writable;
        logic prog_input;
        logic free_group;
    } kpa_attr_t;

endpackage : kpa_pkg

// >>> design/kpa_key_sync.sv
// Two-flop synchroniser and rising-edge detector for the keypad keys.
// Assumes the keys are raw, debounced pin levels from outside ref_clk.
`timescale 1ns/1ps
`default_nettype none
module kpa_key_sync
    import kpa_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Raw keys and press pulses
    input wire kpa_keys_t keys_pin,
    output kpa_keys_t key_press
);
    kpa_keys_t meta;
    kpa_keys_t sync;
    kpa_keys_t prev;
    kpa_keys_t next_meta;
    kpa_keys_t next_sync;
    kpa_keys_t next_prev;

    always_comb
    begin
        next_meta = keys_pin;
        next_sync = meta;
        next_prev = sync;
        if (srst)
        begin
            next_meta = '0;
            next_sync = '0;
            next_prev = '0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        meta <= next_meta;
        sync <= next_sync;
        prev <= next_prev;
    end

    // A press is one pulse on the rising edge of the synchronised key.
    assign key_press = sync & ~prev;
endmodule : kpa_key_sync
`default_nettype wire

// >>> verification/kpa_access_monitor.sv
// Checker for the keypad access block, bound to its ports.
// Assumes one clock domain and an active-high synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module kpa_access_monitor
    import kpa_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Watched ports
    input wire logic four_quad,
    input wire kpa_attr_t attr,
    input wire kpa_index_t disp_index,
    input wire logic disp_flash,
    input wire logic disp_blank,
    input wire logic wr_strobe,
    input wire kpa_index_t wr_index,
    input wire logic save_strobe,
    input wire logic default_strobe,
    input wire logic default_four_quad,
    input wire logic apply_deferred
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);
    property p_flash_seen;
        disp_flash |-> !disp_blank;
    endproperty
    a_flash_seen: assert property (p_flash_seen) else $error("flash on denied data");
    property p_flash_cause;
        $rose(disp_flash) && disp_index.param != 6'h00 |->
            $past(attr.writable) && !$past(attr.prog_input);
    endproperty
    a_flash_cause: assert property (p_flash_cause) else $error("flash on fixed param");
    property p_edit_index;
        disp_flash && $past(disp_flash) |-> $stable(disp_index);
    endproperty
    a_edit_index: assert property (p_edit_index) else $error("index moved in edit");
    property p_wr_end;
        wr_strobe |-> disp_flash ##1 ($fell(disp_flash) && !wr_strobe);
    endproperty
    a_wr_end: assert property (p_wr_end) else $error("write outside edit end");
    property p_wr_code;
        wr_strobe |-> wr_index.param != 6'h00 && wr_index == disp_index;
    endproperty
    a_wr_code: assert property (p_wr_code) else $error("code entry written");
    property p_save;
        save_strobe |-> disp_index.param == 6'h00 && !default_strobe ##1 !save_strobe;
    endproperty
    a_save: assert property (p_save) else $error("bad save pulse");
    property p_default;
        default_strobe |-> disp_index.param == 6'h00 && default_four_quad == four_quad;
    endproperty
    a_default: assert property (p_default) else $error("bad default pulse");
    property p_apply;
        apply_deferred |-> !disp_flash ##1 !apply_deferred;
    endproperty
    a_apply: assert property (p_apply) else $error("bad apply pulse");
    c_save: cover property (save_strobe);
    c_default: cover property (default_strobe);
    c_apply: cover property (apply_deferred);
endmodule : kpa_access_monitor
bind kpa_access kpa_access_monitor u_mon (.ref_clk(ref_clk), .srst(srst),
    .four_quad(four_quad), .attr(attr), .disp_index(disp_index), .disp_flash(disp_flash),
    .disp_blank(disp_blank), .wr_strobe(wr_strobe), .wr_index(wr_index),
    .save_strobe(save_strobe), .default_strobe(default_strobe),
    .default_four_quad(default_four_quad), .apply_deferred(apply_deferred));
`default_nettype wire

// >>> verification/kpa_store_model.sv
// Parameter store model answering the access block.
// Assumes params 6'h14 up are invisible, 1 read-only, 2 input-driven.
`timescale 1ns/1ps
`default_nettype none
module kpa_store_model
    import kpa_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Block side
    input wire kpa_index_t disp_index,
    input wire logic wr_strobe,
    input wire kpa_index_t wr_index,
    input wire logic [9:0] wr_data,
    input wire logic default_strobe,
    output kpa_attr_t attr,
    output logic [9:0] store_data
);
    logic [9:0] mem [0:2047] = '{default: 10'h000};
    assign attr = '{visible: disp_index.param < 6'h14, writable: disp_index.param != 6'h01,
        prog_input: disp_index.param == 6'h02, free_group: disp_index == 11'h045};
    assign store_data = mem[disp_index];
    always @(posedge ref_clk)
    begin
        if (default_strobe)
        begin
            mem <= '{default: 10'h000};
        end
        else if (wr_strobe)
        begin
            mem[wr_index] <= wr_data;
        end
    end
endmodule : kpa_store_model
`default_nettype wire

// >>> verification/kpa_access_bench.sv
// Self-checking bench for the keypad access block.
// Assumes a key acts within a few cycles of its pin edge.
`timescale 1ns/1ps
`default_nettype none
`include "kpa_defines.svh"
module kpa_access_bench
    import kpa_pkg::*;
;
    localparam int K_L = 5;
    localparam int K_R = 4;
    localparam int K_U = 3;
    localparam int K_D = 2;
    localparam int K_M = 1;
    localparam int K_RS = 0;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    kpa_keys_t keys_pin = '0;
    logic [9:0] saved_sec_code = `KPA_CODE_L1;
    logic four_quad = 1'b1;
    kpa_attr_t attr;
    kpa_index_t disp_index, wr_index;
    logic [9:0] store_data, disp_data, wr_data;
    logic disp_flash, disp_blank, wr_strobe, save_strobe, default_strobe;
    logic default_four_quad, apply_deferred;
    logic saw_wr, saw_save, saw_def, saw_app;
    int fails = 0;
    int checks = 0;
    int cycles = 0;
    always #12.5 ref_clk = ~ref_clk;
    kpa_access dut (.ref_clk(ref_clk), .srst(srst), .keys_pin(keys_pin), .four_quad(four_quad),
        .attr(attr), .store_data(store_data), .saved_sec_code(saved_sec_code),
        .disp_index(disp_index), .disp_data(disp_data), .disp_flash(disp_flash),
        .disp_blank(disp_blank), .wr_strobe(wr_strobe), .wr_index(wr_index),
        .wr_data(wr_data), .save_strobe(save_strobe), .default_strobe(default_strobe),
        .default_four_quad(default_four_quad), .apply_deferred(apply_deferred));
    kpa_store_model store (.ref_clk(ref_clk), .disp_index(disp_index), .wr_strobe(wr_strobe),
        .wr_index(wr_index), .wr_data(wr_data), .default_strobe(default_strobe),
        .attr(attr), .store_data(store_data));
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (wr_strobe) saw_wr <= 1'b1;
        if (save_strobe) saw_save <= 1'b1;
        if (default_strobe) saw_def <= 1'b1;
        if (apply_deferred) saw_app <= 1'b1;
        if (cycles == 60000)
        begin
            fails++;
            final_report();
        end
    end
    task automatic final_report;
        if (fails == 0 && checks > 0)
        begin
            $display("No errors found");
        end
        else
        begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic press(input int k);
        keys_pin[k] = 1'b1;
        repeat (6) @(negedge ref_clk);
        keys_pin[k] = 1'b0;
        repeat (6) @(negedge ref_clk);
    endtask : press
    task automatic do_reset(input logic [9:0] code);
        srst = 1'b1;
        saved_sec_code = code;
        repeat (20) @(negedge ref_clk);
        srst = 1'b0;
        repeat (2) @(negedge ref_clk);
    endtask : do_reset
    task automatic goto(input logic [4:0] m, input logic [5:0] p);
        int n;
        n = 0;
        while (disp_index.menu !== m && n < 40)
        begin
            n++;
            press(disp_index.menu < m ? K_R : K_L);
        end
        while (disp_index.param !== p && n < 140)
        begin
            n++;
            press(disp_index.param < p ? K_U : K_D);
        end
        check("index", disp_index, {m, p});
    endtask : goto
    // Edits the shown value to v by single steps and accepts it.
    task automatic enter(input logic [9:0] v);
        int n;
        n = 0;
        {saw_wr, saw_save, saw_def, saw_app} = 4'h0;
        press(K_M);
        check("edit", disp_flash, 1'b1);
        while (disp_data !== v && n < 300)
        begin
            n++;
            press(disp_data < v ? K_U : K_D);
        end
        press(K_M);
    endtask : enter
    task automatic mode_check(input logic exp);
        press(K_M);
        check("flash", disp_flash, exp);
        press(K_M);
    endtask : mode_check
    task automatic t_browse;
        goto(5'h01, 6'h03);
        check("blank", disp_blank, 1'b0);
        check("data", disp_data, 10'h000);
        mode_check(1'b0);
        goto(5'h01, 6'h05);
        enter(10'h003);
        check("wr", saw_wr, 1'b1);
        check("stored", store.mem[11'h045], 10'h003);
        goto(5'h02, 6'h03);
        press(K_L);
        check("recall", disp_index, 11'h045);
    endtask : t_browse
    task automatic t_codes;
        goto(5'h01, 6'h00);
        enter(10'h007);
        goto(5'h01, 6'h03);
        mode_check(1'b0);
        goto(5'h01, 6'h00);
        enter(`KPA_CODE_L1);
        goto(5'h01, 6'h03);
        mode_check(1'b1);
        goto(5'h01, 6'h15);
        check("hidden", disp_blank, 1'b1);
        goto(5'h01, 6'h00);
        enter(`KPA_CODE_L2);
        goto(5'h01, 6'h15);
        mode_check(1'b1);
    endtask : t_codes
    task automatic t_commands;
        goto(5'h0B, 6'h0C);
        enter(10'h005);
        press(K_RS);
        check("apply", saw_app, 1'b1);
        goto(5'h0B, 6'h00);
        enter(`KPA_CODE_SAVE);
        press(K_RS);
        check("save", saw_save, 1'b1);
        goto(5'h01, 6'h00);
        enter(`KPA_CODE_DEF4Q);
        press(K_RS);
        check("default", {saw_def, default_four_quad}, 2'b11);
        check("cleared", store.mem[11'h045], 10'h000);
    endtask : t_commands
    // Assigns a private code under level 2 and saves it.
    task automatic t_secsave;
        goto(`KPA_MENU_MISC, `KPA_PAR_SEC);
        check("sec shown", disp_data, `KPA_CODE_L1);
        enter(10'h100);
        check("sec refused", saw_wr, 1'b0);
        enter(10'h00A);
        check("sec written", saw_wr, 1'b1);
        goto(`KPA_MENU_MISC, 6'h00);
        enter(`KPA_CODE_SAVE);
        press(K_RS);
        check("sec saved", saw_save, 1'b1);
        goto(5'h01, 6'h03);
        check("locked", disp_blank, 1'b1);
    endtask : t_secsave
    // A one-quadrant unit answers only its own default code.
    task automatic t_one_quad;
        four_quad = 1'b0;
        do_reset(`KPA_CODE_L1);
        goto(5'h01, 6'h05);
        enter(10'h003);
        goto(5'h01, 6'h00);
        enter(`KPA_CODE_DEF4Q);
        press(K_RS);
        check("no default", {saw_def, default_four_quad}, 2'b00);
        check("kept", store.mem[11'h045], 10'h003);
        enter(`KPA_CODE_DEF1Q);
        press(K_RS);
        check("default 1q", {saw_def, default_four_quad}, 2'b10);
        check("cleared 1q", store.mem[11'h045], 10'h000);
    endtask : t_one_quad
    task automatic t_level3;
        do_reset(10'h00A);
        goto(5'h01, 6'h03);
        check("denied", disp_blank, 1'b1);
        goto(5'h01, 6'h00);
        enter(`KPA_CODE_L1);
        goto(5'h01, 6'h03);
        check("still", disp_blank, 1'b1);
        goto(5'h01, 6'h00);
        enter(10'h00A);
        goto(5'h01, 6'h05);
        mode_check(1'b0);
        goto(5'h01, 6'h00);
        enter(`KPA_CODE_L1);
        goto(5'h01, 6'h03);
        mode_check(1'b1);
        do_reset(10'h000);
        goto(5'h01, 6'h03);
        mode_check(1'b1);
    endtask : t_level3
    initial
    begin
        do_reset(`KPA_CODE_L1);
        t_browse();
        t_codes();
        t_commands();
        t_secsave();
        t_level3();
        t_one_quad();
        final_report();
    end
endmodule : kpa_access_bench
`default_nettype wire
